// file: iam_defs.svh
`ifndef IAM_DEFS_SVH
`define IAM_DEFS_SVH

// next header protocol numbers for the fixed protocol choices
`define IAM_PROTO_ICMP6   8'h3A
`define IAM_PROTO_UDP     8'h11
`define IAM_PROTO_TCP     8'h06

// width of the compared part of the source address
`define IAM_SIP_W         32

// reset values of the configuration registers
`define IAM_RST_BYTE      8'h00
`define IAM_RST_WORD      32'h0000_0000

// pipeline depth from frame strobe to verdict
`define IAM_LATENCY       2

`endif

// file: iam_pkg.sv
`include "iam_defs.svh"

package iam_pkg;

  typedef enum logic [2:0] {
    IAM_NH_ANY      = 3'h0,
    IAM_NH_SPECIFIC = 3'h1,
    IAM_NH_ICMP     = 3'h2,
    IAM_NH_UDP      = 3'h3,
    IAM_NH_TCP      = 3'h4
  } iam_nh_mode_t;

  typedef enum logic [1:0] {
    IAM_HOP_ANY     = 2'h0,
    IAM_HOP_ZERO    = 2'h1,
    IAM_HOP_NONZERO = 2'h2
  } iam_hop_mode_t;

  // criteria of one access_control_entry
  typedef struct packed {
    iam_nh_mode_t  nh_mode;
    logic [7:0]    nh_value;
    logic          sip_specific;
    logic [31:0]   source_ip_criterion;
    logic [31:0]   source_ip_bit_mask;
    iam_hop_mode_t hop_mode;
    logic          icmp_type_specific;
    logic [7:0]    icmp_type;
    logic          icmp_code_specific;
    logic [7:0]    icmp_code;
  } iam_cfg_t;

  // header fields of one received frame from the parser
  typedef struct packed {
    logic          is_ipv6;
    logic [7:0]    next_header;
    logic [31:0]   src_low;
    logic [7:0]    hop_limit;
    logic [7:0]    icmp_type;
    logic [7:0]    icmp_code;
  } iam_frame_t;

  typedef enum logic [1:0] {
    IAM_ST_IDLE  = 2'b00,
    IAM_ST_EVAL  = 2'b01,
    IAM_ST_REPLY = 2'b11
  } iam_state_t;

endpackage : iam_pkg

// file: iam_cfg_store.sv
`timescale 1ns/10ps
`default_nettype none

// holds the entry criteria; a new set is taken whole on the load strobe so
// the matcher never sees a half-written entry
module iam_cfg_store
  import iam_pkg::*;
(
  input  wire logic     clk_in,
  input  wire logic     rst_in,
  input  wire logic     load_in,
  input  wire iam_cfg_t cfg_in,
  output var  iam_cfg_t cfg_out
);

  iam_cfg_t cfg_ff;
  iam_cfg_t nxt_cfg;

  always_comb begin
    nxt_cfg = cfg_ff;
    if (load_in) begin
      nxt_cfg = cfg_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign cfg_out = cfg_ff;

endmodule : iam_cfg_store

`default_nettype wire

// file: iam_entry_matcher.sv
// How it works
// - next-header criterion any: the next header field is ignored
// - ICMP, UDP or TCP choice: only that protocol hits; ICMP also enables its set
// - source criterion any: the source address is ignored
// - source specific: only the lowest 32 source bits are compared
// - a zero mask bit makes that source bit irrelevant
// - compare address AND mask against frame bits AND same mask
// - hop criterion zero: frames with hop limit above zero never hit
// - hop non-zero: hop limit above zero may hit; any ignores it
// - ICMP type any: the ICMP type is ignored
// - ICMP type specific: hit only if ICMP type equals 8-bit value
// - ICMP code any: the ICMP code is ignored
// - ICMP code specific: hit only if ICMP code equals 8-bit value
`timescale 1ns/10ps
`default_nettype none
`include "iam_defs.svh"

module iam_entry_matcher
  import iam_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       cfg_load_in,
  input  wire iam_cfg_t   cfg_in,
  input  wire logic       frame_valid_in,
  input  wire iam_frame_t frame_in,
  output logic            result_valid_out,
  output logic            hit_out,
  output logic            busy_out,
  output iam_cfg_t        cfg_out
);

  iam_cfg_t cfg_q;

  iam_cfg_store u_cfg_store (
    .clk_in  (clk_in),
    .rst_in  (rst_in),
    .load_in (cfg_load_in),
    .cfg_in  (cfg_in),
    .cfg_out (cfg_q)
  );

  function automatic logic byte_ok(input logic       specific,
                                   input logic [7:0] want,
                                   input logic [7:0] got);
    byte_ok = !specific || (want == got);
  endfunction : byte_ok

  // stage 1: every criterion group keeps its own registered partial match, so
  // the comparator tree stays off the verdict path at 250 MHz. the
  // partials load every cycle; only frames flagged valid reach a verdict

  // decodes of the incoming frame and of the entry used by the groups below
  logic                  is_icmp;
  logic                  is_udp;
  logic                  is_tcp;
  logic [`IAM_SIP_W-1:0] sip_mask;
  logic                  any_icmp_spec;

  always_comb begin
    is_icmp       = frame_in.next_header == `IAM_PROTO_ICMP6;
    is_udp        = frame_in.next_header == `IAM_PROTO_UDP;
    is_tcp        = frame_in.next_header == `IAM_PROTO_TCP;
    sip_mask      = cfg_q.source_ip_bit_mask;
    any_icmp_spec = cfg_q.icmp_type_specific || cfg_q.icmp_code_specific;
  end

  // next header group
  logic st_nh_ff;
  logic nxt_st_nh;

  always_comb begin
    unique case (cfg_q.nh_mode)
      IAM_NH_ANY: begin
        nxt_st_nh = 1'b1;
      end
      IAM_NH_SPECIFIC: begin
        nxt_st_nh = byte_ok(1'b1, cfg_q.nh_value,
                            frame_in.next_header);
      end
      IAM_NH_ICMP: begin
        nxt_st_nh = is_icmp;
      end
      IAM_NH_UDP: begin
        nxt_st_nh = is_udp;
      end
      IAM_NH_TCP: begin
        nxt_st_nh = is_tcp;
      end
      // codes above the tcp choice are unused; such an entry never hits
      default: begin
        nxt_st_nh = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_nh_ff <= 1'b0;
    end else begin
      st_nh_ff <= nxt_st_nh;
    end
  end

  // source address group; the frame interface carries only the low word,
  // so the upper address bits can never take part in a match
  logic st_sip_ff;
  logic nxt_st_sip;

  always_comb begin
    if (!cfg_q.sip_specific) begin
      nxt_st_sip = 1'b1;
    end else begin
      nxt_st_sip = (cfg_q.source_ip_criterion & sip_mask) ==
                   (frame_in.src_low & sip_mask);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_sip_ff <= 1'b0;
    end else begin
      st_sip_ff <= nxt_st_sip;
    end
  end

  // hop limit group
  logic st_hop_ff;
  logic nxt_st_hop;

  always_comb begin
    unique case (cfg_q.hop_mode)
      IAM_HOP_ANY: begin
        nxt_st_hop = 1'b1;
      end
      IAM_HOP_ZERO: begin
        nxt_st_hop = frame_in.hop_limit == 8'h00;
      end
      IAM_HOP_NONZERO: begin
        nxt_st_hop = frame_in.hop_limit != 8'h00;
      end
      // the fourth code is unused; an entry holding it never hits
      default: begin
        nxt_st_hop = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_hop_ff <= 1'b0;
    end else begin
      st_hop_ff <= nxt_st_hop;
    end
  end

  // ICMP group: type and code belong to the ICMP set of the entry, so a
  // specific criterion turns away every frame that does not carry ICMP
  logic st_icmp_ff;
  logic nxt_st_icmp;

  always_comb begin
    if (cfg_q.nh_mode == IAM_NH_ICMP || any_icmp_spec) begin
      nxt_st_icmp = byte_ok(cfg_q.icmp_type_specific, cfg_q.icmp_type,
                            frame_in.icmp_type)
                 && byte_ok(cfg_q.icmp_code_specific, cfg_q.icmp_code,
                            frame_in.icmp_code)
                 && (!any_icmp_spec || is_icmp);
    end else begin
      nxt_st_icmp = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_icmp_ff <= 1'b0;
    end else begin
      st_icmp_ff <= nxt_st_icmp;
    end
  end

  // frame kind group; non-IPv6 frames never hit an IPv6 entry
  logic st_v6_ff;
  logic nxt_st_v6;

  always_comb begin
    nxt_st_v6 = frame_in.is_ipv6;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_v6_ff <= 1'b0;
    end else begin
      st_v6_ff <= nxt_st_v6;
    end
  end

  // stage 2 sequencer: a new frame may arrive every cycle; the state only
  // tracks whether the pipe still holds work. EVAL means the partials
  // were taken from a valid frame at the last edge
  iam_state_t state_ff;
  iam_state_t nxt_state;
  logic       busy_ff;
  logic       nxt_busy;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IAM_ST_IDLE: begin
        if (frame_valid_in) begin
          nxt_state = IAM_ST_EVAL;
        end
      end
      IAM_ST_EVAL: begin
        if (frame_valid_in) begin
          nxt_state = IAM_ST_EVAL;
        end else begin
          nxt_state = IAM_ST_REPLY;
        end
      end
      IAM_ST_REPLY: begin
        if (frame_valid_in) begin
          nxt_state = IAM_ST_EVAL;
        end else begin
          nxt_state = IAM_ST_IDLE;
        end
      end
      default: begin
        nxt_state = IAM_ST_IDLE;
      end
    endcase
    // busy is registered beside the state so the pin leaves a flop
    nxt_busy = nxt_state != IAM_ST_IDLE;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= IAM_ST_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= nxt_busy;
    end
  end

  // verdict group: one verdict per frame, in frame order, one cycle after
  // its partials were registered
  logic valid_ff;
  logic nxt_valid;
  logic hit_ff;
  logic nxt_hit;

  always_comb begin
    nxt_valid = 1'b0;
    nxt_hit   = 1'b0;
    if (state_ff == IAM_ST_EVAL) begin
      nxt_valid = 1'b1;
      nxt_hit   = st_v6_ff && st_nh_ff && st_sip_ff
               && st_hop_ff && st_icmp_ff;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_ff <= 1'b0;
      hit_ff   <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
      hit_ff   <= nxt_hit;
    end
  end

  // mirror of the active criteria; it trails the store by one cycle, so
  // software reading it back sees a load two cycles after the strobe
  iam_cfg_t cfg_out_ff;
  iam_cfg_t nxt_cfg_out;

  always_comb begin
    nxt_cfg_out = cfg_q;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_out_ff <= '0;
    end else begin
      cfg_out_ff <= nxt_cfg_out;
    end
  end

  assign result_valid_out = valid_ff;
  assign hit_out          = hit_ff;
  assign busy_out         = busy_ff;
  assign cfg_out          = cfg_out_ff;

endmodule : iam_entry_matcher

`default_nettype wire

// file: iam_matcher_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "iam_defs.svh"
module iam_chk
  import iam_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       cfg_load_in,
  input  wire iam_cfg_t   cfg_in,
  input  wire logic       frame_valid_in,
  input  wire iam_frame_t frame_in,
  input  wire logic       result_valid_out,
  input  wire logic       hit_out,
  input  wire logic       busy_out,
  input  wire iam_cfg_t   cfg_out
);
  logic [3:0] ld_ff;
  iam_frame_t f1_ff;
  iam_frame_t f;
  iam_cfg_t   c;
  logic       r;
  // verdicts are judged only when no load landed near the frame, so the
  // visible cfg_out is the criteria the frame was matched against
  assign c = cfg_out;
  assign r = result_valid_out && ld_ff == 4'h0;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) ld_ff <= 4'hF;
    else ld_ff <= {ld_ff[2:0], cfg_load_in};
  end
  always_ff @(posedge clk_in) begin
    f1_ff <= frame_in;
    f <= f1_ff;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_LAT: assert property (frame_valid_in
    |-> ##2 result_valid_out) else $error("late verdict");
  AST_NOV: assert property (!result_valid_out
    |-> !hit_out) else $error("hit without verdict");
  AST_NH: assert property (r && c.nh_mode == IAM_NH_SPECIFIC
    && f.next_header != c.nh_value |-> !hit_out) else $error("nh value");
  AST_PR: assert property (r && c.nh_mode == IAM_NH_TCP
    && f.next_header != `IAM_PROTO_TCP |-> !hit_out) else $error("proto");
  AST_SIP: assert property (r && c.sip_specific
    && |((f.src_low ^ c.source_ip_criterion) & c.source_ip_bit_mask)
    |-> !hit_out) else $error("source");
  AST_HOP: assert property (r && c.hop_mode == IAM_HOP_ZERO
    && f.hop_limit != 8'h00 |-> !hit_out) else $error("hop");
  AST_TY: assert property (r && c.icmp_type_specific
    && f.icmp_type != c.icmp_type |-> !hit_out) else $error("type");
  AST_CO: assert property (r && c.icmp_code_specific
    && f.icmp_code != c.icmp_code |-> !hit_out) else $error("code");
  AST_IC: assert property (r && c.icmp_type_specific
    && f.next_header != `IAM_PROTO_ICMP6 |-> !hit_out) else $error("icmp");
  AST_ANY: assert property (r && f.is_ipv6
    && c.nh_mode == IAM_NH_ANY && !c.sip_specific && c.hop_mode == IAM_HOP_ANY
    && !c.icmp_type_specific && !c.icmp_code_specific |-> hit_out)
    else $error("any");
  C_HIT: cover property (r && hit_out);
  C_MISS: cover property (r && !hit_out);
  C_LD: cover property (cfg_load_in ##1 frame_valid_in);
endmodule : iam_chk
bind iam_entry_matcher iam_chk u_chk (.clk_in, .rst_in, .cfg_load_in,
  .cfg_in, .frame_valid_in, .frame_in, .result_valid_out, .hit_out,
  .busy_out, .cfg_out);
`default_nettype wire

// file: iam_parser.sv
`timescale 1ns/10ps
`default_nettype none
// ingress parser stand-in: plays queued frames back to back; between
// frames the header bus toggles so stale fields never look valid
module iam_parser
  import iam_pkg::*;
(
  input  wire logic  clk_in,
  output logic       valid_out,
  output iam_frame_t frame_out
);
  iam_frame_t q[$];
  initial begin
    valid_out = 1'b0;
    frame_out = '0;
  end
  always @(negedge clk_in) begin
    valid_out <= q.size() != 0;
    frame_out <= q.size() != 0 ? q.pop_front() : ~frame_out;
  end
endmodule : iam_parser
`default_nettype wire

// file: iam_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "iam_defs.svh"
module tb;
  import iam_pkg::*;
  logic       clk_in, rst_in, cfg_load_in, frame_valid_in;
  logic       result_valid_out, hit_out, busy_out;
  iam_cfg_t   cfg_in, cfg_out, act;
  iam_frame_t frame_in;
  logic [95:0] rv;
  int         err_count, cmp_count;
  logic       exp_q[$];
  logic [1:0] fv_hist_ff;
  iam_parser p (.clk_in, .valid_out(frame_valid_in), .frame_out(frame_in));
  iam_entry_matcher uut (.clk_in, .rst_in, .cfg_load_in, .cfg_in,
    .frame_valid_in, .frame_in, .result_valid_out, .hit_out, .busy_out,
    .cfg_out);
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task chk(input logic [95:0] seen, input logic [95:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wrap_up;
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  function logic model(iam_cfg_t c, iam_frame_t f);
    logic ok;
    ok = f.is_ipv6;
    case (c.nh_mode)
      IAM_NH_ANY: ;
      IAM_NH_SPECIFIC: ok &= f.next_header == c.nh_value;
      IAM_NH_ICMP: ok &= f.next_header == `IAM_PROTO_ICMP6;
      IAM_NH_UDP: ok &= f.next_header == `IAM_PROTO_UDP;
      IAM_NH_TCP: ok &= f.next_header == `IAM_PROTO_TCP;
      default: ok = 1'b0;
    endcase
    ok &= !c.sip_specific || ((f.src_low ^ c.source_ip_criterion)
      & c.source_ip_bit_mask) == 32'h0;
    if (c.hop_mode == IAM_HOP_ZERO) ok &= f.hop_limit == 8'h00;
    if (c.hop_mode == IAM_HOP_NONZERO) ok &= f.hop_limit != 8'h00;
    ok &= !c.icmp_type_specific || f.next_header == `IAM_PROTO_ICMP6
      && f.icmp_type == c.icmp_type;
    ok &= !c.icmp_code_specific || f.next_header == `IAM_PROTO_ICMP6
      && f.icmp_code == c.icmp_code;
    return ok;
  endfunction : model
  // next_header, src_low, icmp_type and icmp_code are each steered toward the entry in half the frames, hop_limit to zero in half, so hits are not rare
  task send(input int n);
    iam_frame_t f;
    repeat (n) begin
      rv = {$urandom, $urandom, $urandom};
      f = rv[64:0];
      f.is_ipv6 = rv[88] | rv[89];
      if (rv[90]) f.next_header = rv[91] ? act.nh_value
        : act.nh_mode == IAM_NH_UDP ? `IAM_PROTO_UDP
        : act.nh_mode == IAM_NH_TCP ? `IAM_PROTO_TCP : `IAM_PROTO_ICMP6;
      if (rv[92]) f.src_low = act.source_ip_criterion ^ (rv[31:0]
        & ~act.source_ip_bit_mask);
      if (rv[93]) f.hop_limit = 8'h00;
      if (rv[94]) f.icmp_type = act.icmp_type;
      if (rv[95]) f.icmp_code = act.icmp_code;
      exp_q.push_back(model(act, f));
      p.q.push_back(f);
    end
    for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(negedge clk_in);
    if (exp_q.size() != 0) begin
      err_count++;
      wrap_up();
    end
  endtask : send
  // frames seen at the last two edges; the pipe is busy while either holds
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) fv_hist_ff <= 2'h0;
    else fv_hist_ff <= {fv_hist_ff[0], frame_valid_in};
  end
  always @(negedge clk_in) begin
    if (result_valid_out === 1'b1)
      chk(hit_out, exp_q.size() ? exp_q.pop_front() : 1'bx, "hit");
    chk(busy_out, |fv_hist_ff, "busy");
  end
  initial begin
    void'($urandom(32'hE1A63A7E));
    err_count = 0;
    cmp_count = 0;
    rst_in = 1'b1;
    cfg_load_in = 1'b0;
    cfg_in = '0;
    act = '0;
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    chk(cfg_out, '0, "cfg_reset");
    send(20);
    for (int m = 0; m < 6; m++) begin
      for (int h = 0; h < 3; h++) begin
        cfg_in = {$urandom, $urandom, $urandom};
        cfg_in.nh_mode = iam_nh_mode_t'(m);
        cfg_in.hop_mode = iam_hop_mode_t'(h);
        if (h == 1) cfg_in.source_ip_bit_mask = 32'hFFFFFFFE;
        if (m == 0) cfg_in.source_ip_bit_mask = 32'h00000000;
        cfg_load_in = 1'b1;
        @(negedge clk_in);
        cfg_load_in = 1'b0;
        act = cfg_in;
        cfg_in = ~cfg_in;
        send(24);
        chk(cfg_out, act, "cfg");
      end
    end
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    act = '0;
    chk(cfg_out, '0, "cfg_rereset");
    send(8);
    wrap_up();
  end
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
